/* dv/scu_router_asserts.sv */
// concurrent checks on line routing and byte arbitration of the router
`timescale 1ns/1ps
module scu_router_chk (
   input wire logic               core_clk_i,
   input wire logic               rst_n_i,
   input wire logic               clk_en_i,
   input wire scu_pkg::scu_bus_t  bus_i,
   input wire logic               card_fitted_i,
   input wire logic               uplink_power_control_i,
   input wire logic               ser_rx_i,
   input wire logic               ser_tx_o,
   input wire logic               ser_tx_oe_o,
   input wire logic               sat_rx_i,
   input wire logic               sat_tx_o,
   input wire logic               mc_bus_rx_i,
   input wire logic               mc_bus_tx_o,
   input wire logic               mc_port_tx_i,
   input wire logic               mc_port_rx_o,
   input wire scu_pkg::scu_byte_t pkt_tx_i,
   input wire scu_pkg::scu_byte_t upc_tx_i,
   input wire logic               pkt_tx_ready_o
);
   import scu_pkg::*;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // shadow of the port field, kept from bus writes so no read cycle is stolen
   logic [2:0] port_ff;
   wire  [2:0] nxt_port = (clk_en_i && bus_i.wr && bus_i.addr == SCU_REG_CFG) ? bus_i.wdata[SCU_F_PORT +: 3] : port_ff;
   // aux on the shared port takes the service path off the wire
   logic       aux_sel_ff;
   wire        nxt_aux_sel = (clk_en_i && bus_i.wr && bus_i.addr == SCU_REG_AUX) ?
                             bus_i.wdata[SCU_F_AUXSEL] : aux_sel_ff;
   // sampled reset keeps the release edge out of the routing antecedents; s_both_req does not sample it
   wire        run      = rst_n_i && clk_en_i && !card_fitted_i;
   wire        ser_m    = run && !aux_sel_ff && port_ff <= 3'h2;
   wire        loc_m    = run && port_ff == 3'h4;
   wire        rem_m    = run && port_ff == 3'h5;
   always_ff @(posedge core_clk_i) begin
      port_ff <= rst_n_i ? nxt_port : SCU_PORT_RST;
      aux_sel_ff <= rst_n_i ? nxt_aux_sel : 1'b0;
   end
   sequence s_both_req;
      uplink_power_control_i && port_ff == 3'h3 && upc_tx_i.valid && pkt_tx_i.valid;
   endsequence
   property p_ser_up; ser_m |=> sat_tx_o == $past(ser_rx_i); endproperty
   a_ser_up: assert property (p_ser_up) else $error("serial uplink altered");
   property p_ser_dn; ser_m |=> ser_tx_o == $past(sat_rx_i); endproperty
   a_ser_dn: assert property (p_ser_dn) else $error("serial downlink altered");
   property p_link_off; (loc_m || rem_m) |-> !ser_tx_oe_o; endproperty
   a_link_off: assert property (p_link_off) else $error("service port driven in link mode");
   property p_loc_dn; loc_m |=> mc_bus_tx_o == $past(sat_rx_i); endproperty
   a_loc_dn: assert property (p_loc_dn) else $error("local bus misses channel data");
   property p_loc_up; loc_m |=> sat_tx_o == $past(mc_bus_rx_i); endproperty
   a_loc_up: assert property (p_loc_up) else $error("local bus not sent to channel");
   property p_rem_dn; rem_m |=> mc_port_rx_o == $past(sat_rx_i); endproperty
   a_rem_dn: assert property (p_rem_dn) else $error("control port misses channel data");
   property p_rem_up; rem_m |=> sat_tx_o == $past(mc_port_tx_i); endproperty
   a_rem_up: assert property (p_rem_up) else $error("control port not sent to channel");
   property p_upc_first; s_both_req |-> !pkt_tx_ready_o; endproperty
   a_upc_first: assert property (p_upc_first) else $error("packet taken before control byte");
endmodule // scu_router_chk

bind scu_router scu_router_chk u_chk (.core_clk_i, .rst_n_i, .clk_en_i, .bus_i, .card_fitted_i,
   .uplink_power_control_i, .ser_rx_i, .ser_tx_o, .ser_tx_oe_o, .sat_rx_i, .sat_tx_o, .mc_bus_rx_i,
   .mc_bus_tx_o, .mc_port_tx_i, .mc_port_rx_o, .pkt_tx_i, .upc_tx_i, .pkt_tx_ready_o);

/* dv/scu_sat_peer.sv */
// satellite-side uart model facing the router's channel line
`timescale 1ns/1ps
module scu_sat_peer #(
   parameter int unsigned BIT_CLKS = 100
)(
   input  wire logic core_clk_i,
   input  wire logic sat_tx_i,
   output logic      sat_rx_o
);
   initial sat_rx_o = 1'b1;
   // frame bit 0 is the start bit, data lsb first, line returns high
   task automatic send(input logic [10:0] fr, input int nb);
      for (int i = 0; i < nb; i++) begin
         sat_rx_o <= fr[i];
         repeat (BIT_CLKS) @(posedge core_clk_i);
      end
      sat_rx_o <= 1'b1;
   endtask
   // stops at the centre of the last bit so a back-to-back start is not missed
   task automatic recv(input int nb, input int wait_max, output logic [10:0] fr, output bit got);
      int n;
      fr = '1;
      n  = 0;
      while (sat_tx_i !== 1'b0 && n < wait_max) begin
         @(posedge core_clk_i);
         n++;
      end
      got = (sat_tx_i === 1'b0);
      if (got) begin
         repeat (BIT_CLKS / 2) @(posedge core_clk_i);
         for (int i = 0; i < nb; i++) begin
            fr[i] = sat_tx_i;
            if (i < nb - 1)
               repeat (BIT_CLKS) @(posedge core_clk_i);
         end
      end
   endtask
endmodule // scu_sat_peer

/* dv/testbench.sv */
// self-checking testbench for the service channel uart router
`timescale 1ns/1ps
module testbench;
   import scu_pkg::*;
   localparam logic [7:0] DAT   [3] = '{8'ha5, 8'h4b, 8'hc3};
   localparam logic       LEN8  [3] = '{1'b1, 1'b0, 1'b1};
   localparam logic [1:0] PAR   [3] = '{2'h0, 2'h1, 2'h2};
   localparam logic [2:0] MODES [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
   logic        core_clk_i, rst_n_i, card_fitted_i, upc_on, sat_ovr, ser_rx_i, mc_bus_rx_i, mc_port_tx_i;
   logic        sat_val, learned, ser_tx, ser_oe, sat_tx, sat_rx, peer_rx, mcb_tx, mcp_rx, shared_en, card_svc;
   logic        pkt_ready, upc_ready, card_aux, pkt_wrap, aux_tx, aux_act, p2mp;
   logic [31:0] rdata, remote;
   logic [10:0] fr;
   logic [7:0]  rx_last;
   bit          got;
   scu_bus_t    bus;
   scu_byte_t   pkt_tx, upc_tx, pkt_rx;
   int          err_total, num_checks, lo_cnt;
   // the bench stands in for the far end while routing is probed cycle by cycle
   assign sat_rx = sat_ovr ? sat_val : peer_rx;
   scu_router dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .bus_i(bus), .rdata_o(rdata),
      .card_fitted_i(card_fitted_i), .p2mp_i(p2mp), .uplink_power_control_i(upc_on), .ser_rx_i(ser_rx_i),
      .ser_tx_o(ser_tx), .ser_tx_oe_o(ser_oe), .sat_rx_i(sat_rx), .sat_tx_o(sat_tx), .mc_bus_rx_i(mc_bus_rx_i),
      .mc_bus_tx_o(mcb_tx), .mc_port_tx_i(mc_port_tx_i), .mc_port_rx_o(mcp_rx), .shared_port_en_o(shared_en),
      .card_svc_en_o(card_svc), .card_aux_en_o(card_aux), .pkt_tx_i(pkt_tx), .pkt_tx_learned_i(learned),
      .pkt_tx_ready_o(pkt_ready), .upc_tx_i(upc_tx), .upc_tx_ready_o(upc_ready), .pkt_rx_o(pkt_rx),
      .pkt_wrap_o(pkt_wrap), .aux_rx_i(1'b1), .aux_tx_o(aux_tx), .aux_active_o(aux_act),
      .remote_addr_o(remote));
   scu_sat_peer #(.BIT_CLKS(SCU_CLK_HZ / 115200)) peer (.core_clk_i(core_clk_i), .sat_tx_i(sat_tx), .sat_rx_o(peer_rx));
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) if (pkt_rx.valid === 1'b1) rx_last <= pkt_rx.data;
   task automatic final_report();
      if (err_total == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got_v, input logic [31:0] exp, input string what);
      num_checks++;
      if (got_v !== exp) begin
         err_total++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got_v, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk_i);
      bus <= '0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
      @(posedge core_clk_i);
      bus <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge core_clk_i);
      bus <= '0;
      #1;
      chk(rdata & m, exp, "register read");
   endtask
   // rate and ceiling both at index 12, the fastest, to keep frames short
   function automatic logic [31:0] cfgv(input logic len8, input logic [1:0] par, input logic [2:0] port);
      return {12'h0, 4'hc, 3'h0, 1'b0, 1'b0, port, 1'b0, par, len8, 4'hc};
   endfunction
   function automatic logic [10:0] frame(input logic [7:0] d, input logic len8, input logic [1:0] par);
      logic [10:0] f;
      logic        p;
      f         = '1;
      p         = len8 ? ^d : ^d[6:0];
      f[0]      = 1'b0;
      f[1 +: 7] = d[6:0];
      if (len8)
         f[8] = d[7];
      if (par != 2'h0)
         f[8 + 32'(len8)] = (par == 2'h2) ? ~p : p;
      return f;
   endfunction
   task automatic push(input bit upc, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk_i);
      if (upc)
         upc_tx <= '{1'b1, d};
      else
         pkt_tx <= '{1'b1, d};
      do begin
         @(posedge core_clk_i);
         n++;
      end while ((upc ? upc_ready : pkt_ready) !== 1'b1 && n < 9000);
      chk(32'(n < 9000), 32'h1, "byte accepted");
      if (upc)
         upc_tx <= '0;
      else
         pkt_tx <= '0;
   endtask
   task automatic route(input logic [2:0] m);
      logic [3:0] prev;
      logic [3:0] cur;
      wr(SCU_REG_CFG, cfgv(1'b1, 2'h0, m));
      sat_ovr <= 1'b1;
      prev = 4'h0;
      for (int i = 0; i < 9; i++) begin
         @(posedge core_clk_i);
         cur = 4'(i * 5 + 3);
         {ser_rx_i, mc_bus_rx_i, mc_port_tx_i, sat_val} <= cur;
         #1;
         if (i > 0) begin
            chk(sat_tx, m < 3 ? prev[3] : m == 4 ? prev[2] : prev[1], "uplink route");
            chk(m < 3 ? ser_tx : m == 4 ? mcb_tx : mcp_rx, prev[0], "downlink route");
            chk(ser_oe, 32'(m < 3), "service port drive");
         end
         prev = cur;
      end
      sat_ovr <= 1'b0;
   endtask
   initial begin
      bus     = '0;
      pkt_tx  = '0;
      upc_tx  = '0;
      rx_last = '0;
      // serial inputs idle high so the default pass-through mode sends no break
      {p2mp, card_fitted_i, upc_on, sat_ovr, ser_rx_i, mc_bus_rx_i, mc_port_tx_i, sat_val, learned} = 9'h01f;
      rst_n_i = 1'b0;
      repeat (16) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      rd(SCU_REG_CFG, 32'hffff_ffff, {12'h0, SCU_MAXRATE_RST, 3'h0, SCU_HIRATE_RST, 1'b0, SCU_PORT_RST, 1'b0,
         SCU_PAR_RST, SCU_LEN8_RST, SCU_RATE_RST});
      rd(SCU_REG_AUX, 32'h0000_3033, 32'h0);
      rd(4'h2, 32'hffff_ffff, 32'h0);
      rd(SCU_REG_STAT, 32'h7, 32'h2);
      card_fitted_i <= 1'b1;
      rd(SCU_REG_STAT, 32'h7, 32'h1);
      chk({shared_en, card_svc}, 2'b01, "card ports");
      wr(SCU_REG_AUX, 32'h0000_1000);
      #1;
      chk({aux_act, card_aux}, 2'b11, "card aux channel");
      card_fitted_i <= 1'b0;
      wr(SCU_REG_AUX, 32'h0000_0110);
      sat_ovr <= 1'b1;
      sat_val <= 1'b0;
      #1;
      chk({aux_act, aux_tx, ser_oe}, 3'b100, "aux owns shared port");
      wr(SCU_REG_AUX, 32'h0);
      #1;
      chk(aux_act, 1'b0, "aux released");
      sat_ovr <= 1'b0;
      foreach (MODES[k]) route(MODES[k]);
      for (int k = 0; k < 3; k++) begin
         wr(SCU_REG_CFG, cfgv(LEN8[k], PAR[k], SCU_P_PKT));
         fork
            push(1'b0, DAT[k]);
            peer.recv(9 + 32'(LEN8[k]) + 32'(PAR[k] != 2'h0), 6000, fr, got);
         join
         chk(fr, frame(DAT[k], LEN8[k], PAR[k]), "sent frame");
         peer.send(frame(DAT[k], LEN8[k], PAR[k]), 9 + 32'(LEN8[k]) + 32'(PAR[k] != 2'h0));
         chk(rx_last, DAT[k], "received byte");
      end
      peer.send(frame(8'h99, 1'b1, 2'h2) ^ 11'h200, 11);
      chk(rx_last, DAT[2], "bad parity dropped");
      wr(SCU_REG_REMOTE, 32'h0a00_0102);
      p2mp <= 1'b1;
      #1;
      chk(remote, 32'h0a00_0102, "one p2mp peer");
      p2mp <= 1'b0;
      #1;
      chk(remote, 32'h0, "no peer outside p2mp");
      learned <= 1'b0;
      fork
         push(1'b0, 8'h66);
         peer.recv(11, 6000, fr, got);
      join
      chk(got, 1'b0, "unlearned byte");
      upc_on  <= 1'b1;
      learned <= 1'b1;
      fork
         push(1'b1, 8'h3c);
         push(1'b0, 8'h5a);
         begin
            peer.recv(11, 6000, fr, got);
            chk(fr, frame(8'h3c, 1'b1, 2'h2), "control byte first");
            peer.recv(11, 6000, fr, got);
            chk(fr, frame(8'h5a, 1'b1, 2'h2), "packet byte next");
         end
      join
      // ceiling below the requested rate stretches every bit
      wr(SCU_REG_CFG, (cfgv(1'b1, 2'h0, 3'h6) & 32'hfff0_ffff) | 32'h000b_0000);
      #1;
      chk(pkt_wrap, 1'b1, "wrapped serial mode");
      fork
         push(1'b0, 8'h01);
         begin
            lo_cnt = 0;
            while (sat_tx !== 1'b0 && lo_cnt < 3000) begin
               @(posedge core_clk_i);
               lo_cnt++;
            end
            lo_cnt = 0;
            while (sat_tx === 1'b0 && lo_cnt < 3000) begin
               @(posedge core_clk_i);
               lo_cnt++;
            end
         end
      join
      chk(lo_cnt, SCU_CLK_HZ / 76800, "clamped bit period");
      final_report();
   end
   // about 40k cycles are expected; the limit leaves ample margin
   initial begin
      #2_500_000;
      err_total++;
      final_report();
   end
endmodule // testbench

/* src/scu_pkg.sv */
// package for the service channel uart router
package scu_pkg;
   localparam int unsigned SCU_CLK_HZ      = 40000000;
   localparam int unsigned SCU_NUM_RATES   = 13;
   localparam logic [3:0]  SCU_RATE_RST    = 4'h7;
   localparam logic        SCU_LEN8_RST    = 1'b1;
   localparam logic [1:0]  SCU_PAR_RST     = 2'h0;
   localparam logic [2:0]  SCU_PORT_RST    = 3'h2;
   localparam logic [1:0]  SCU_AUXIF_RST   = 2'h0;
   localparam logic [1:0]  SCU_AUXMODE_RST = 2'h0;
   localparam logic        SCU_HIRATE_RST  = 1'b0;
   localparam logic [3:0]  SCU_MAXRATE_RST = 4'hc;
   // register offsets
   localparam logic [3:0]  SCU_REG_CFG     = 4'h0;
   localparam logic [3:0]  SCU_REG_AUX     = 4'h4;
   localparam logic [3:0]  SCU_REG_STAT    = 4'h8;
   localparam logic [3:0]  SCU_REG_REMOTE  = 4'hc;
   // cfg field positions
   localparam int unsigned SCU_F_RATE   = 0;
   localparam int unsigned SCU_F_LEN8   = 4;
   localparam int unsigned SCU_F_PAR    = 5;
   localparam int unsigned SCU_F_PORT   = 8;
   localparam int unsigned SCU_F_HIRATE = 12;
   localparam int unsigned SCU_F_MAXR   = 16;
   // aux field positions
   localparam int unsigned SCU_F_AUXIF  = 0;
   localparam int unsigned SCU_F_AUXMD  = 4;
   localparam int unsigned SCU_F_AUXSEL = 8;
   localparam int unsigned SCU_F_IDRAUX = 12;

   typedef enum logic [1:0] {SCU_PAR_NONE, SCU_PAR_EVEN, SCU_PAR_ODD} scu_par_t;
   typedef enum logic [2:0] {SCU_P_RS232, SCU_P_RS422, SCU_P_RS485, SCU_P_PKT,
                             SCU_P_LOCAL, SCU_P_REMOTE, SCU_P_PKT2SER} scu_port_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } scu_byte_t;

   // register bus request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [31:0] wdata;
   } scu_bus_t;

   // bit periods in clocks for each rate index
   function automatic logic [19:0] scu_div(input logic [3:0] idx);
      int unsigned b;
      case (idx)
         4'h0: b = 110;
         4'h1: b = 150;
         4'h2: b = 300;
         4'h3: b = 600;
         4'h4: b = 1200;
         4'h5: b = 2400;
         4'h6: b = 4800;
         4'h7: b = 9600;
         4'h8: b = 19200;
         4'h9: b = 38400;
         4'ha: b = 57600;
         4'hb: b = 76800;
         default: b = 115200;
      endcase
      return 20'(SCU_CLK_HZ / b);
   endfunction
endpackage

/* src/scu_router.sv */
// service channel uart and port routing multiplexer
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module scu_router (
   input  wire logic              core_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              clk_en_i,
   input  wire scu_pkg::scu_bus_t bus_i,
   output logic [31:0]            rdata_o,
   input  wire logic              card_fitted_i,
   input  wire logic              p2mp_i,
   input  wire logic              uplink_power_control_i,
   input  wire logic              ser_rx_i,
   output logic                   ser_tx_o,
   output logic                   ser_tx_oe_o,
   input  wire logic              sat_rx_i,
   output logic                   sat_tx_o,
   input  wire logic              mc_bus_rx_i,
   output logic                   mc_bus_tx_o,
   input  wire logic              mc_port_tx_i,
   output logic                   mc_port_rx_o,
   output logic                   shared_port_en_o,
   output logic                   card_svc_en_o,
   output logic                   card_aux_en_o,
   input  wire scu_pkg::scu_byte_t pkt_tx_i,
   input  wire logic              pkt_tx_learned_i,
   output logic                   pkt_tx_ready_o,
   input  wire scu_pkg::scu_byte_t upc_tx_i,
   output logic                   upc_tx_ready_o,
   output scu_pkg::scu_byte_t     pkt_rx_o,
   output logic                   pkt_wrap_o,
   input  wire logic              aux_rx_i,
   output logic                   aux_tx_o,
   output logic                   aux_active_o,
   output logic [31:0]            remote_addr_o
);
   import scu_pkg::*;

   logic [31:0] cfg_ff, aux_ff, remote_ff;
   logic [31:0] rdata_ff;

   wire wr_cfg    = bus_i.wr && bus_i.addr == SCU_REG_CFG;
   wire wr_aux    = bus_i.wr && bus_i.addr == SCU_REG_AUX;
   wire wr_remote = bus_i.wr && bus_i.addr == SCU_REG_REMOTE;

   wire [3:0] rate_req  = cfg_ff[SCU_F_RATE +: 4];
   wire       len8      = cfg_ff[SCU_F_LEN8];
   wire [1:0] par       = cfg_ff[SCU_F_PAR +: 2];
   wire [2:0] port_raw  = cfg_ff[SCU_F_PORT +: 3];
   wire       hirate_en = cfg_ff[SCU_F_HIRATE];
   wire [3:0] max_rate  = cfg_ff[SCU_F_MAXR +: 4];
   wire [1:0] auxif_raw = aux_ff[SCU_F_AUXIF +: 2];
   wire [1:0] aux_mode  = aux_ff[SCU_F_AUXMD +: 2];
   wire       aux_sel   = aux_ff[SCU_F_AUXSEL];
   wire [1:0] idr_aux   = aux_ff[SCU_F_IDRAUX +: 2];

   // rate clamp to what the overhead can carry
   wire [3:0] rate_idx  = (rate_req > max_rate) ? max_rate : rate_req;
   wire [3:0] rate_sel  = (rate_idx > 4'(SCU_NUM_RATES - 1)) ? 4'(SCU_NUM_RATES - 1) : rate_idx;
   wire [19:0] bit_div  = scu_div(rate_sel);

   // rs485 unavailable on option card ports, fall back to rs422
   wire [2:0] port_m    = (card_fitted_i && port_raw == 3'(SCU_P_RS485)) ? 3'(SCU_P_RS422) :
                          (port_raw > 3'(SCU_P_PKT2SER)) ? 3'(SCU_P_RS485) : port_raw;
   wire [1:0] auxif     = (card_fitted_i && auxif_raw == 2'h2) ? 2'h1 : auxif_raw;

   wire is_serial = port_m <= 3'(SCU_P_RS485);
   wire is_pkt    = port_m == 3'(SCU_P_PKT) || port_m == 3'(SCU_P_PKT2SER);
   wire is_local  = port_m == 3'(SCU_P_LOCAL);
   wire is_remote = port_m == 3'(SCU_P_REMOTE);
   wire is_link   = is_local || is_remote;

   // shared port carries either service or aux unless the card is fitted
   wire aux_on_shared = !card_fitted_i && aux_sel;
   assign shared_port_en_o = !card_fitted_i && !(is_link && !aux_sel);
   assign card_svc_en_o    = card_fitted_i && !is_link;
   assign card_aux_en_o    = card_fitted_i;
   assign aux_active_o     = (aux_on_shared || card_fitted_i) &&
                             (aux_mode != 2'h0 || (card_fitted_i && idr_aux != 2'h0));
   assign aux_tx_o         = aux_active_o ? sat_rx_i : 1'b1;
   wire svc_phys_ok        = is_serial && !aux_on_shared;

   // uart transmitter
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_st_t;
   tx_st_t tx_st_ff;
   logic [19:0] tx_cnt_ff;
   logic [10:0] tx_sh_ff;
   logic [3:0]  tx_n_ff;
   logic        tx_src_ff;

   wire has_par       = par != 2'(SCU_PAR_NONE);
   wire [3:0] tx_len  = 4'h9 + (len8 ? 4'h1 : 4'h0) + (has_par ? 4'h1 : 4'h0) - 4'h1;
   // power-control traffic has priority; bridged bytes wait between messages
   wire tx_take_upc   = is_pkt && uplink_power_control_i && upc_tx_i.valid;
   wire tx_take_pkt   = is_pkt && pkt_tx_i.valid && pkt_tx_learned_i && !tx_take_upc;
   wire tx_drop_pkt   = is_pkt && pkt_tx_i.valid && !pkt_tx_learned_i && !tx_take_upc;
   wire tx_idle       = tx_st_ff == TX_IDLE;
   assign upc_tx_ready_o = tx_idle && tx_take_upc;
   assign pkt_tx_ready_o = (tx_idle && tx_take_pkt) || tx_drop_pkt;
   wire [7:0] tx_byte = tx_take_upc ? upc_tx_i.data : pkt_tx_i.data;
   wire [7:0] tx_mask = len8 ? 8'hff : 8'h7f;
   wire tx_par        = ^(tx_byte & tx_mask) ^ (par == 2'(SCU_PAR_ODD));
   wire [9:0] tx_body = len8 ? {tx_par, tx_byte, 1'b0} : {1'b1, tx_par, tx_byte[6:0], 1'b0};
   wire [10:0] tx_frame = has_par ? {1'b1, tx_body} :
                          (len8 ? {2'h3, tx_byte, 1'b0} : {3'h7, tx_byte[6:0], 1'b0});
   wire tx_start      = tx_idle && (tx_take_upc || tx_take_pkt);
   wire tx_tick       = tx_cnt_ff == bit_div - 20'h1;
   wire uart_tx_line  = tx_idle ? 1'b1 : tx_sh_ff[0];

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         tx_st_ff  <= TX_IDLE;
         tx_cnt_ff <= 20'h0;
         tx_sh_ff  <= 11'h7ff;
         tx_n_ff   <= 4'h0;
         tx_src_ff <= 1'b0;
      end else if (clk_en_i) begin
         case (tx_st_ff)
            TX_IDLE: begin
               tx_cnt_ff <= 20'h0;
               if (tx_start) begin
                  tx_st_ff  <= TX_SHIFT;
                  tx_sh_ff  <= tx_frame;
                  tx_n_ff   <= tx_len;
                  tx_src_ff <= tx_take_upc;
               end
            end
            TX_SHIFT: begin
               tx_cnt_ff <= tx_tick ? 20'h0 : tx_cnt_ff + 20'h1;
               if (tx_tick) begin
                  tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                  tx_n_ff  <= tx_n_ff - 4'h1;
                  if (tx_n_ff == 4'h0) begin
                     tx_st_ff <= TX_IDLE;
                  end
               end
            end
            default: tx_st_ff <= TX_IDLE;
         endcase
      end
   end

   // uart receiver on the satellite side, used in packet modes
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_st_t;
   rx_st_t rx_st_ff;
   logic [19:0] rx_cnt_ff;
   logic [8:0]  rx_sh_ff;
   logic [3:0]  rx_n_ff;
   scu_byte_t   rx_out_ff;
   logic        rx_err_ff;

   wire [3:0] rx_len  = 4'h7 + (len8 ? 4'h1 : 4'h0) + (has_par ? 4'h1 : 4'h0);
   wire rx_half       = rx_cnt_ff == {1'b0, bit_div[19:1]};
   wire rx_tick       = rx_cnt_ff == bit_div - 20'h1;
   wire [8:0] rx_shn  = {sat_rx_i, rx_sh_ff[8:1]};
   // align received bits to lsb regardless of frame width
   wire [8:0] rx_al   = rx_shn >> (4'h9 - rx_len);
   wire [7:0] rx_data = len8 ? rx_al[7:0] : {1'b0, rx_al[6:0]};
   wire rx_pbit       = len8 ? rx_al[8] : rx_al[7];
   wire rx_perr       = has_par && (rx_pbit != (^rx_data ^ (par == 2'(SCU_PAR_ODD))));

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rx_st_ff  <= RX_IDLE;
         rx_cnt_ff <= 20'h0;
         rx_sh_ff  <= 9'h0;
         rx_n_ff   <= 4'h0;
         rx_out_ff <= '0;
         rx_err_ff <= 1'b0;
      end else if (clk_en_i) begin
         rx_out_ff.valid <= 1'b0;
         case (rx_st_ff)
            RX_IDLE: begin
               rx_cnt_ff <= 20'h0;
               if (!sat_rx_i && is_pkt) begin
                  rx_st_ff <= RX_START;
               end
            end
            RX_START: begin
               rx_cnt_ff <= rx_cnt_ff + 20'h1;
               if (rx_half) begin
                  rx_cnt_ff <= 20'h0;
                  rx_n_ff   <= rx_len;
                  rx_st_ff  <= sat_rx_i ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               rx_cnt_ff <= rx_tick ? 20'h0 : rx_cnt_ff + 20'h1;
               if (rx_tick) begin
                  if (rx_n_ff == 4'h0) begin
                     rx_st_ff <= RX_IDLE;
                     // stop bit must be high, else frame dropped
                     rx_out_ff.valid <= sat_rx_i && !rx_err_ff;
                     rx_err_ff <= 1'b0;
                  end else begin
                     rx_sh_ff <= rx_shn;
                     rx_n_ff  <= rx_n_ff - 4'h1;
                     if (rx_n_ff == 4'h1) begin
                        rx_out_ff.data <= rx_data;
                        rx_err_ff      <= rx_perr;
                     end
                  end
               end
            end
            default: rx_st_ff <= RX_IDLE;
         endcase
      end
   end

   assign pkt_rx_o   = rx_out_ff;
   assign pkt_wrap_o = port_m == 3'(SCU_P_PKT2SER);

   // line routing: serial modes are one-register pass-throughs with no interpretation
   logic sat_tx_ff, ser_tx_ff, mc_bus_ff, mc_port_ff;
   wire sat_tx_n  = is_serial  ? (svc_phys_ok ? ser_rx_i : 1'b1) :
                    is_local   ? mc_bus_rx_i :
                    is_remote  ? mc_port_tx_i :
                    uart_tx_line;
   wire ser_tx_n  = svc_phys_ok ? sat_rx_i : 1'b1;
   wire mc_bus_n  = is_local ? sat_rx_i : 1'b1;
   wire mc_port_n = is_remote ? sat_rx_i : 1'b1;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         sat_tx_ff  <= 1'b1;
         ser_tx_ff  <= 1'b1;
         mc_bus_ff  <= 1'b1;
         mc_port_ff <= 1'b1;
      end else if (clk_en_i) begin
         sat_tx_ff  <= sat_tx_n;
         ser_tx_ff  <= ser_tx_n;
         mc_bus_ff  <= mc_bus_n;
         mc_port_ff <= mc_port_n;
      end
   end

   assign sat_tx_o     = sat_tx_ff;
   assign ser_tx_o     = ser_tx_ff;
   assign ser_tx_oe_o  = svc_phys_ok && (shared_port_en_o || card_svc_en_o);
   assign mc_bus_tx_o  = mc_bus_ff;
   assign mc_port_rx_o = mc_port_ff;
   // a single remote address register holds the one p2mp peer
   assign remote_addr_o = (is_pkt && p2mp_i) ? remote_ff : 32'h0;

   // register file
   wire [31:0] stat_w = {24'h0, rx_err_ff, tx_src_ff, card_fitted_i, aux_active_o,
                         hirate_en, port_m};
   wire [31:0] rd_mux = bus_i.addr == SCU_REG_CFG    ? cfg_ff :
                        bus_i.addr == SCU_REG_AUX    ? aux_ff :
                        bus_i.addr == SCU_REG_STAT   ? stat_w :
                        bus_i.addr == SCU_REG_REMOTE ? remote_ff : 32'h0;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cfg_ff <= {12'h0, SCU_MAXRATE_RST, 3'h0, SCU_HIRATE_RST, 1'b0, SCU_PORT_RST,
                    1'b0, SCU_PAR_RST, SCU_LEN8_RST, SCU_RATE_RST};
         aux_ff <= {18'h0, 2'h0, 3'h0, 1'b0, 2'h0, SCU_AUXMODE_RST, 2'h0, SCU_AUXIF_RST};
         remote_ff <= 32'h0;
         rdata_ff  <= 32'h0;
      end else if (clk_en_i) begin
         if (wr_cfg) begin
            cfg_ff <= bus_i.wdata & 32'h000f_177f;
         end
         if (wr_aux) begin
            aux_ff <= bus_i.wdata & 32'h0000_3133;
         end
         if (wr_remote) begin
            remote_ff <= bus_i.wdata;
         end
         rdata_ff <= bus_i.rd ? rd_mux : 32'h0;
      end
   end

   assign rdata_o = rdata_ff;
endmodule // scu_router
